/* File: dac_calibration_control.sv */
// Calibration engine, clock divider and coefficient register access
module dac_calibration_control
    import calib_pkg::*;
#(
    parameter int CAL_LEN = CAL_TICKS // Calibration clock ticks per self-calibration
) (
    input wire logic sys_clk_i, // DAC sample clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic [4:0] reg_addr_i, // Register address
    input wire logic reg_wr_i, // Register write strobe
    input wire logic [7:0] reg_wdata_i, // Register write data
    output logic [7:0] reg_rdata_o, // Register read data
    output logic external_ref_select_o, // 1 powers down internal reference
    output logic calib_clk_tick_o, // Calibration clock enable pulse
    output logic calib_busy_o // Self-calibration running
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic external_ref_select;
    logic calib_clock_enable;
    logic [2:0] calib_clock_divide;
    logic calib_done;
    logic calib_start;
    logic coef_write_strobe;
    logic coef_read_strobe;
    logic coef_clear;
    logic [5:0] coef_address;
    logic [5:0] coef_value;
    calib_state_t calib_state;
    logic [7:0] div_cnt;
    logic [7:0] cal_cnt;
    logic read_wait;
    logic clear_seen;

    coef_if cif ();

    coef_store u_store (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .port(cif.mem)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire wr_ctl = reg_wr_i && (reg_addr_i == ADDR_SPI_CTL);
    wire wr_cfg = reg_wr_i && (reg_addr_i == ADDR_DATA_CFG);
    wire wr_setup = reg_wr_i && (reg_addr_i == ADDR_CALIB_SETUP);
    wire wr_memctl = reg_wr_i && (reg_addr_i == ADDR_MEM_CONTROL);
    wire wr_addr = reg_wr_i && (reg_addr_i == ADDR_COEF_ADDRESS);
    wire wr_value = reg_wr_i && (reg_addr_i == ADDR_COEF_VALUE);
    // One control write may carry several requests at once
    wire req_start = wr_memctl && reg_wdata_i[BIT_START];
    wire req_write = wr_memctl && reg_wdata_i[BIT_WRITE];
    wire req_read = wr_memctl && reg_wdata_i[BIT_READ];
    wire req_clear = wr_memctl && reg_wdata_i[BIT_CLEAR];
    // Terminal count: 2^(8-code) sample clocks per tick
    wire [7:0] div_last = DIV_COUNT_MAX >> calib_clock_divide;
    wire tick = calib_clock_enable && (div_cnt == div_last);
    wire cal_end = calib_start && tick && (cal_cnt == 8'(CAL_LEN - 1));
    wire [7:0] memctl_rd = {calib_done, calib_start, 2'b00,
                            coef_write_strobe, coef_read_strobe, 1'b0, coef_clear};

    assign cif.addr = coef_address;
    assign cif.wdata = coef_value;
    assign cif.we = coef_write_strobe && !cif.clr_busy;
    // Clear request drops once the walk has begun, so the store cannot start it twice
    assign cif.clr = coef_clear && !clear_seen;
    assign external_ref_select_o = external_ref_select;
    assign calib_clk_tick_o = tick;
    assign calib_busy_o = calib_start;

    // Read-back image of each register; unmapped addresses read zero
    wire [7:0] spi_ctl_rd = {7'h00, external_ref_select};
    wire [7:0] data_cfg_rd = {7'h00, calib_clock_enable};
    wire [7:0] setup_rd = {2'b00, calib_state, 1'b0, calib_clock_divide};
    wire [7:0] addr_rd = {2'b00, coef_address};
    wire [7:0] value_rd = {2'b00, coef_value};

    always_comb begin
        unique case (reg_addr_i)
            ADDR_SPI_CTL: reg_rdata_o = spi_ctl_rd;
            ADDR_DATA_CFG: reg_rdata_o = data_cfg_rd;
            ADDR_CALIB_SETUP: reg_rdata_o = setup_rd;
            ADDR_MEM_CONTROL: reg_rdata_o = memctl_rd;
            ADDR_COEF_ADDRESS: reg_rdata_o = addr_rd;
            ADDR_COEF_VALUE: reg_rdata_o = value_rd;
            default: reg_rdata_o = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Reference selection
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            external_ref_select <= 1'b0;
        end else if (wr_ctl) begin
            external_ref_select <= reg_wdata_i[BIT_EXT_REF];
        end
    end

    // ----------------------------------------
    // Calibration clock setup
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            calib_clock_enable <= 1'b0;
        end else if (wr_cfg) begin
            calib_clock_enable <= reg_wdata_i[BIT_CAL_CLK_EN];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            calib_clock_divide <= DIV_RESET;
        end else if (wr_setup) begin
            calib_clock_divide <= reg_wdata_i[2:0];
        end
    end

    // ----------------------------------------
    // Coefficient address
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            coef_address <= COEF_ADDR_RESET;
        end else if (wr_addr) begin
            coef_address <= reg_wdata_i[COEF_W-1:0];
        end
    end

    // ----------------------------------------
    // Calibration clock divider
    // ----------------------------------------
    // The count restarts while disabled, so the first tick after enabling is a full period
    wire div_restart = srst_i || !calib_clock_enable || tick;

    always_ff @(posedge sys_clk_i) begin
        if (div_restart) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Self-calibration
    // ----------------------------------------
    typedef enum logic [0:0] {
        CAL_IDLE = 1'b0,
        CAL_RUN = 1'b1
    } cal_phase_t;

    cal_phase_t cal_phase;
    cal_phase_t next_cal_phase;

    // A start request while running is ignored rather than restarting the count
    wire cal_launch = req_start && (cal_phase == CAL_IDLE);
    wire cal_step = calib_start && tick;

    assign calib_start = (cal_phase == CAL_RUN);

    always_comb begin
        next_cal_phase = cal_phase;
        unique case (cal_phase)
            CAL_IDLE: begin
                if (cal_launch) begin
                    next_cal_phase = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (cal_end) begin
                    next_cal_phase = CAL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cal_phase <= CAL_IDLE;
        end else begin
            cal_phase <= next_cal_phase;
        end
    end

    // Done stays set until the next calibration is launched
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            calib_done <= 1'b0;
        end else if (cal_end) begin
            calib_done <= 1'b1;
        end else if (cal_launch) begin
            calib_done <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cal_cnt <= 8'h00;
        end else if (cal_launch) begin
            cal_cnt <= 8'h00;
        end else if (cal_step) begin
            cal_cnt <= cal_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Coefficient access strobes
    // ----------------------------------------
    // Store accesses are held off while the store walks its clear
    wire store_idle = !cif.clr_busy;
    wire write_done = cif.we;
    wire read_step = coef_read_strobe && store_idle;
    wire read_done = read_step && read_wait;
    wire clear_done = coef_clear && clear_seen && store_idle;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            coef_write_strobe <= 1'b0;
        end else if (req_write) begin
            coef_write_strobe <= 1'b1;
        end else if (write_done) begin
            coef_write_strobe <= 1'b0;
        end
    end

    // The store answers a cycle after the address settles, so a read waits one cycle
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            coef_read_strobe <= 1'b0;
            read_wait <= 1'b0;
        end else if (req_read) begin
            coef_read_strobe <= 1'b1;
            read_wait <= 1'b0;
        end else if (read_done) begin
            coef_read_strobe <= 1'b0;
            read_wait <= 1'b0;
        end else if (read_step) begin
            read_wait <= 1'b1;
        end
    end

    // A clear is finished only after the store was seen busy and then idle again
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            coef_clear <= 1'b0;
            clear_seen <= 1'b0;
        end else if (req_clear) begin
            coef_clear <= 1'b1;
            clear_seen <= 1'b0;
        end else if (clear_done) begin
            coef_clear <= 1'b0;
            clear_seen <= 1'b0;
        end else if (coef_clear && cif.clr_busy) begin
            clear_seen <= 1'b1;
        end
    end

    // ----------------------------------------
    // Coefficient data register
    // ----------------------------------------
    // Host writes lose against a pending read, which owns the register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            coef_value <= COEF_DEFAULT;
        end else if (read_done) begin
            coef_value <= cif.rdata;
        end else if (wr_value && !coef_read_strobe) begin
            coef_value <= reg_wdata_i[COEF_W-1:0];
        end
    end

    // ----------------------------------------
    // Calibration state report
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            calib_state <= CS_COEF_CLEAR;
        end else if (cal_end) begin
            calib_state <= CS_SELF;
        end else if (clear_done) begin
            calib_state <= CS_COEF_CLEAR;
        end else if (write_done) begin
            calib_state <= CS_USER;
        end
    end
endmodule : dac_calibration_control

/* File: calib_pkg.sv */
// Register map, field positions and constants for the calibration control block
package calib_pkg;
    localparam logic [4:0] ADDR_SPI_CTL = 5'h00;
    localparam logic [4:0] ADDR_DATA_CFG = 5'h02;
    localparam logic [4:0] ADDR_CALIB_SETUP = 5'h0E;
    localparam logic [4:0] ADDR_MEM_CONTROL = 5'h0F;
    localparam logic [4:0] ADDR_COEF_ADDRESS = 5'h10;
    localparam logic [4:0] ADDR_COEF_VALUE = 5'h11;
    localparam int BIT_EXT_REF = 0;
    localparam int BIT_CAL_CLK_EN = 0;
    localparam int BIT_DONE = 7;
    localparam int BIT_START = 6;
    localparam int BIT_WRITE = 3;
    localparam int BIT_READ = 2;
    localparam int BIT_CLEAR = 0;
    localparam int STATE_LSB = 4;
    localparam int COEF_W = 6;
    localparam int COEF_DEPTH = 64;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [5:0] COEF_ADDR_RESET = 6'h00;
    localparam logic [5:0] COEF_DEFAULT = 6'h3F;
    localparam logic [7:0] DIV_COUNT_MAX = 8'hFF;
    localparam int CAL_TICKS = 64;
    typedef enum logic [1:0] {
        CS_COEF_CLEAR = 2'b00,
        CS_SELF = 2'b01,
        CS_USER = 2'b11
    } calib_state_t;
endpackage : calib_pkg

/* File: coef_if.sv */
// Access port of the coefficient store
interface coef_if;
    logic [5:0] addr;
    logic [5:0] wdata;
    logic [5:0] rdata;
    logic we;
    logic clr;
    logic clr_busy;
    modport ctrl (output addr, output wdata, output we, output clr, input rdata, input clr_busy);
    modport mem (input addr, input wdata, input we, input clr, output rdata, output clr_busy);
endinterface : coef_if

/* File: coef_store.sv */
// Coefficient memory with a walking clear to the default value
module coef_store
    import calib_pkg::*;
(
    input wire logic sys_clk_i, // Sample clock
    input wire logic srst_i, // Synchronous reset
    coef_if.mem port // Access port
);
    logic [COEF_W-1:0] mem [COEF_DEPTH];
    logic [5:0] clr_ptr;
    logic clearing;
    logic [COEF_W-1:0] rdata_q;

    assign port.clr_busy = clearing;
    assign port.rdata = rdata_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            clearing <= 1'b1;
            clr_ptr <= COEF_ADDR_RESET;
        end else if (port.clr && !clearing) begin
            clearing <= 1'b1;
            clr_ptr <= COEF_ADDR_RESET;
        end else if (clearing) begin
            clr_ptr <= clr_ptr + 6'h01;
            if (clr_ptr == 6'(COEF_DEPTH - 1)) begin
                clearing <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clearing) begin
            mem[clr_ptr] <= COEF_DEFAULT;
        end else if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        rdata_q <= mem[port.addr];
    end
endmodule : coef_store

/* File: calib_host_model.sv */
// Host model issuing single-byte register accesses
module calib_host_model (
    input wire logic sys_clk_i, // Clock
    input wire logic [7:0] rdata_i, // Read data
    output logic [4:0] addr_o, // Address
    output logic wr_o, // Write pulse
    output logic [7:0] wdata_o // Write data
);
    initial begin
        addr_o = 5'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge sys_clk_i);
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        #1 d = rdata_i;
    endtask : rd
endmodule : calib_host_model

/* File: dac_calibration_control_monitor.sv */
// Port assertions for the calibration control block
module dac_calibration_control_monitor
    import calib_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic srst_i, // Reset
    input wire logic [4:0] reg_addr_i, // Address
    input wire logic reg_wr_i, // Write
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic [7:0] reg_rdata_o, // Read data
    input wire logic external_ref_select_o, // Reference
    input wire logic calib_clk_tick_o, // Tick
    input wire logic calib_busy_o // Busy
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    a_ref_follows: assert property (reg_wr_i && reg_addr_i == ADDR_SPI_CTL
        |=> external_ref_select_o == $past(reg_wdata_i[0])) else $error("ref select wrong");
    a_tick_gated: assert property (reg_addr_i == ADDR_DATA_CFG && !reg_rdata_o[0]
        |-> !calib_clk_tick_o) else $error("tick while disabled");
    a_tick_pulse: assert property (calib_clk_tick_o |=> !calib_clk_tick_o)
        else $error("tick longer than one cycle");
    a_busy_starts: assert property (reg_wr_i && reg_addr_i == ADDR_MEM_CONTROL
        && reg_wdata_i[6] && !calib_busy_o |=> calib_busy_o) else $error("no start");
    a_busy_holds: assert property ($rose(calib_busy_o) |-> calib_busy_o[*2])
        else $error("calibration too short");
    a_done_busy: assert property (calib_busy_o && reg_addr_i == ADDR_MEM_CONTROL
        |-> reg_rdata_o[7:6] == 2'b01) else $error("done or start bit wrong");
    a_addr_back: assert property (reg_wr_i && reg_addr_i == ADDR_COEF_ADDRESS
        ##1 reg_addr_i == ADDR_COEF_ADDRESS |-> reg_rdata_o == {2'b00, $past(reg_wdata_i[5:0])})
        else $error("address readback wrong");
    a_value_width: assert property (reg_addr_i == ADDR_COEF_VALUE
        |-> reg_rdata_o[7:6] == 2'b00) else $error("value upper bits set");
    a_state_code: assert property (reg_addr_i == ADDR_CALIB_SETUP
        |-> reg_rdata_o[5:4] != 2'b10 && reg_rdata_o[7:6] == 2'b00) else $error("bad state");
endmodule : dac_calibration_control_monitor
bind dac_calibration_control dac_calibration_control_monitor u_mon (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .external_ref_select_o(external_ref_select_o), .calib_clk_tick_o(calib_clk_tick_o),
    .calib_busy_o(calib_busy_o));

/* File: tb_top.sv */
// Self-checking bench for the calibration control block
module tb_top
    import calib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    wire logic [4:0] addr;
    wire logic wr;
    wire logic [7:0] wdata;
    wire logic [7:0] rdata;
    wire logic ext;
    wire logic tick;
    wire logic busy;
    int err_total = 0;
    int checked = 0;
    int n;
    int c;
    int mem[int];
    int q[$];
    logic [31:0] rng;
    logic [7:0] v;
    calib_host_model u_host (.sys_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata));
    dac_calibration_control #(.CAL_LEN(4)) u_dut (.sys_clk_i(clk), .srst_i(srst),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .external_ref_select_o(ext), .calib_clk_tick_o(tick), .calib_busy_o(busy));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic results;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        u_host.rd(a, v);
        chk("register", {8'h00, v}, {8'h00, e});
    endtask : rdchk
    task automatic poll(input logic [7:0] m);
        int k;
        for (k = 0; k < 3000; k++) begin
            u_host.rd(ADDR_MEM_CONTROL, v);
            if ((v & m) === 8'h00)
                break;
        end
        if (k == 3000) begin
            err_total++;
            results();
        end
    endtask : poll
    // Cycles between two calibration ticks
    task automatic gap(output int p);
        for (int k = 0; k < 600 && tick !== 1'b1; k++)
            @(negedge clk);
        @(negedge clk);
        p = 1;
        while (tick !== 1'b1 && p < 600) begin
            @(negedge clk);
            p++;
        end
    endtask : gap
    initial begin
        rng = 32'h621B;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (70) @(negedge clk);
        rdchk(ADDR_CALIB_SETUP, 8'h00);
        rdchk(ADDR_MEM_CONTROL, 8'h00);
        rdchk(ADDR_COEF_ADDRESS, 8'h00);
        rdchk(ADDR_COEF_VALUE, 8'h3F);
        rdchk(ADDR_DATA_CFG, 8'h00);
        rdchk(5'h05, 8'h00);
        for (n = 1; n >= 0; n--) begin
            u_host.wr(ADDR_SPI_CTL, 8'(n));
            chk("ref", {15'h0000, ext}, 16'(n));
        end
        u_host.wr(ADDR_CALIB_SETUP, 8'h07);
        c = 0;
        repeat (40) begin
            @(negedge clk);
            c += (tick === 1'b1);
        end
        chk("idle ticks", 16'(c), 16'h0000);
        u_host.wr(ADDR_DATA_CFG, 8'h01);
        for (n = 0; n < 8; n++) begin
            u_host.wr(ADDR_CALIB_SETUP, 8'(n));
            rdchk(ADDR_CALIB_SETUP, 8'(n));
            gap(c);
            chk("period", 16'(c), 16'(1 << (8 - n)));
        end
        for (n = 0; n < 4; n++) begin
            rng = lfsr(rng);
            q.push_back({rng[5:2], 2'(n)});
            mem[q[n]] = rng[13:8];
            u_host.wr(ADDR_COEF_ADDRESS, 8'(q[n]));
            u_host.wr(ADDR_COEF_VALUE, 8'(mem[q[n]]));
            u_host.wr(ADDR_MEM_CONTROL, 8'h08);
            poll(8'h08);
        end
        rdchk(ADDR_CALIB_SETUP, 8'h37);
        for (n = 0; n < 5; n++) begin
            if (n == 4) begin
                u_host.wr(ADDR_MEM_CONTROL, 8'h01);
                poll(8'h01);
                rdchk(ADDR_CALIB_SETUP, 8'h07);
                mem[q[0]] = 8'h3F;
            end
            u_host.wr(ADDR_COEF_VALUE, 8'h00);
            u_host.wr(ADDR_COEF_ADDRESS, 8'(q[n % 4]));
            u_host.wr(ADDR_MEM_CONTROL, 8'h04);
            poll(8'h04);
            rdchk(ADDR_COEF_VALUE, 8'(mem[q[n % 4]]));
        end
        u_host.wr(ADDR_MEM_CONTROL, 8'h40);
        chk("busy", {15'h0000, busy}, 16'h0001);
        poll(8'h40);
        chk("busy", {15'h0000, busy}, 16'h0000);
        rdchk(ADDR_MEM_CONTROL, 8'h80);
        rdchk(ADDR_CALIB_SETUP, 8'h17);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rdchk(ADDR_MEM_CONTROL, 8'h00);
        rdchk(ADDR_CALIB_SETUP, 8'h00);
        results();
    end
endmodule : tb_top
